// ==== verilog/nasd_node_address_decode.v ====
// top of the node address switch decoder
// holds: one-shot switch sampler, byte decode, result latch, supply monitor
// assumes nvm and software values are stable until configValid is high
// assumes switch inputs are already synchronous to clock
// serial variant: only moduleAddress, configValid, ready and underVoltage carry meaning
// field bus variant: nodeId, bitRateSel and both source flags load too
// rate code 0 stands for the fixed 1 MBaud rate
// a later switch move never reaches the outputs; a reset is the only re-arm
`timescale 1ns/100ps
`include "nasd_map.vh"
module nasd_node_address_decode (
    input  wire       clock,
    input  wire       rst_n,
    input  wire [3:0] switchLeft,
    input  wire [3:0] switchRight,
    input  wire       fieldBusVariant,
    input  wire [7:0] softwareAddress,
    input  wire [7:0] nvmNodeId,
    input  wire [2:0] nvmBitRate,
    input  wire       mainSupplyOk,
    output reg  [7:0] moduleAddress,
    output reg  [7:0] nodeId,
    output reg  [2:0] bitRateSel,
    output reg        nodeIdFromNvm,
    output reg        bitRateFromNvm,
    output reg        configValid,
    output reg        ready,
    output reg        underVoltage
);
    localparam [2:0] RATE_1M = 3'h0;

    wire [7:0] switchValue;
    wire       captured;
    reg  [7:0] next_moduleAddress;
    reg  [7:0] next_nodeId;
    reg  [2:0] next_bitRateSel;
    reg        next_nodeIdFromNvm;
    reg        next_bitRateFromNvm;
    wire       loadNow;   // one-cycle load window after capture
    wire       loadBus;   // load window on the field bus variant only

    nasd_switch_sampler uSampler (
        .clock       (clock),
        .rst_n       (rst_n),
        .switchLeft  (switchLeft),
        .switchRight (switchRight),
        .switchValue (switchValue),
        .captured    (captured)
    );

    // true for either reserved software code
    function isReserved;
        input [7:0] v;
        begin
            isReserved = (v == `NASD_CODE_SW_LOW) || (v == `NASD_CODE_SW_HIGH);
        end
    endfunction

    // address from switches; top bit dropped keeps it within 127
    function [7:0] switchAddr;
        input [7:0] v;
        begin
            switchAddr = v[7] ? (v - `NASD_ADDR_OFFSET) : v;
            if (switchAddr > `NASD_ADDR_MAX)
                switchAddr = `NASD_ADDR_MAX;
        end
    endfunction

    // true for codes 0x81..0xFF: offset form of an address
    function inUpperRange;
        input [7:0] v;
        begin
            inUpperRange = v[7] && (v[6:0] != 7'h00);
        end
    endfunction

    // true for codes 0x01..0x7F: address used as set
    function inLowerRange;
        input [7:0] v;
        begin
            inLowerRange = !v[7] && (v[6:0] != 7'h00);
        end
    endfunction

    // decode of the captured byte; defaults are the plain switch case
    always @* begin
        next_nodeIdFromNvm  = 1'b0;
        next_bitRateFromNvm = 1'b0;
        next_bitRateSel     = RATE_1M;
        next_nodeId         = switchAddr(switchValue);
        if (isReserved(switchValue))
            next_moduleAddress = softwareAddress;
        else
            next_moduleAddress = switchAddr(switchValue);
        if (switchValue == `NASD_CODE_SW_LOW) begin
            next_nodeIdFromNvm = 1'b1;
            next_nodeId        = nvmNodeId;
        end else if (switchValue == `NASD_CODE_SW_HIGH) begin
            next_nodeIdFromNvm  = 1'b1;
            next_bitRateFromNvm = 1'b1;
            next_nodeId         = nvmNodeId;
            next_bitRateSel     = nvmBitRate;
        end else if (inUpperRange(switchValue)) begin
            next_bitRateFromNvm = 1'b1;
            next_bitRateSel     = nvmBitRate;
        end
        else if (inLowerRange(switchValue)) begin
            next_nodeId = switchValue;
        end
    end

    // single load strobe: capture seen and nothing latched yet
    assign loadNow = captured && !configValid;
    // field bus outputs load only on that variant; serial keeps them at zero
    assign loadBus = loadNow && fieldBusVariant;

    // serial address latched once; held until reset
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            moduleAddress <= 8'h00;
        end else if (loadNow) begin
            moduleAddress <= next_moduleAddress;
        end
    end

    // result flag; it also closes the load window for good
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            configValid <= 1'b0;
        end else if (loadNow) begin
            configValid <= 1'b1;
        end
    end

    // node id, from the switches or from memory
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            nodeId <= 8'h00;
        end else if (loadBus) begin
            nodeId <= next_nodeId;
        end
    end

    // bit rate code; fixed rate unless memory supplies it
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bitRateSel <= RATE_1M;
        end else if (loadBus) begin
            bitRateSel <= next_bitRateSel;
        end
    end

    // source flag for the node id
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            nodeIdFromNvm <= 1'b0;
        end else if (loadBus) begin
            nodeIdFromNvm <= next_nodeIdFromNvm;
        end
    end

    // source flag for the bit rate
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bitRateFromNvm <= 1'b0;
        end else if (loadBus) begin
            bitRateFromNvm <= next_bitRateFromNvm;
        end
    end

    // undervoltage is a live level, not sticky, so it clears on recovery
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            underVoltage <= 1'b0;
        end else begin
            underVoltage <= !mainSupplyOk;
        end
    end

    // ready needs a latched result and the main supply at once
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ready <= 1'b0;
        end else begin
            ready <= configValid && mainSupplyOk;
        end
    end
endmodule

// ==== shared/nasd_map.vh ====
// constants for the node address switch decoder: codes, limits, timing
// assumes it is included by bare name from design files
`ifndef NASD_MAP_VH
`define NASD_MAP_VH
`define NASD_CODE_SW_LOW    8'h00
`define NASD_CODE_SW_HIGH   8'h80
`define NASD_ADDR_OFFSET    8'h80
`define NASD_ADDR_MAX       8'h7F
`define NASD_NIBBLE_LO      3
`define NASD_NIBBLE_HI      7
`define NASD_CLK_MHZ        200
`define NASD_SETTLE_US      10
`define NASD_SETTLE_CYC     (`NASD_SETTLE_US * `NASD_CLK_MHZ)
// last settle count, sized to the counter: settle cycles minus one
`define NASD_SETTLE_LAST    12'h7CF
`define NASD_CNT_W          12
`endif

// ==== verilog/nasd_switch_sampler.v ====
// one-shot capture of the switch byte after a settle time from reset release
// assumes switch inputs are synchronous and stable during settle
`timescale 1ns/100ps
`include "nasd_map.vh"
module nasd_switch_sampler (
    input  wire       clock,
    input  wire       rst_n,
    input  wire [3:0] switchLeft,
    input  wire [3:0] switchRight,
    output reg  [7:0] switchValue,
    output reg        captured
);
    reg [`NASD_CNT_W-1:0] settleCount;

    // settle count then capture exactly once; never re-armed until reset
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            settleCount <= {`NASD_CNT_W{1'b0}};
            switchValue <= 8'h00;
            captured    <= 1'b0;
        end else if (!captured) begin
            if (settleCount == `NASD_SETTLE_LAST) begin
                switchValue <= {switchRight, switchLeft};
                captured    <= 1'b1;
            end else begin
                settleCount <= settleCount + 1'b1;
            end
        end
    end
endmodule

// ==== sim/nasd_nvm_model.sv ====
// partner: nonvolatile memory and software address setting
// assumes the bench holds seed still across one decode
`timescale 1ns/100ps
module nasd_nvm_model (
    input  wire [15:0] seed,
    output wire [7:0]  softwareAddress,
    output wire [7:0]  nvmNodeId,
    output wire [2:0]  nvmBitRate
);
    // software setting is never 0, so 1..255
    assign softwareAddress = seed[7:0] | 8'h01;
    assign nvmNodeId       = {1'b0, seed[14:8]};
    assign nvmBitRate      = seed[15:13];
endmodule

// ==== sim/nasd_node_address_decode_assertions.sv ====
// checker on the decoder top ports
// assumes memory, software and variant inputs hold still per decode
`timescale 1ns/100ps
module nasd_checker (
    input wire       clock,
    input wire       rst_n,
    input wire       fieldBusVariant,
    input wire       mainSupplyOk,
    input wire       configValid,
    input wire       ready,
    input wire       underVoltage,
    input wire       nodeIdFromNvm,
    input wire       bitRateFromNvm,
    input wire [7:0] softwareAddress,
    input wire [7:0] nvmNodeId,
    input wire [7:0] moduleAddress,
    input wire [7:0] nodeId,
    input wire [2:0] nvmBitRate,
    input wire [2:0] bitRateSel
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_hold; configValid |=> $stable({moduleAddress, nodeId, bitRateSel}); endproperty
    a_hold: assert property (p_hold) else $error("result moved");
    property p_max; configValid |-> moduleAddress <= 8'h7F || moduleAddress == softwareAddress; endproperty
    a_max: assert property (p_max) else $error("address too high");
    property p_fast; configValid && !bitRateFromNvm |-> bitRateSel == 3'h0; endproperty
    a_fast: assert property (p_fast) else $error("rate not fast");
    property p_rate; configValid && bitRateFromNvm |-> bitRateSel == nvmBitRate; endproperty
    a_rate: assert property (p_rate) else $error("memory rate");
    property p_id; configValid && nodeIdFromNvm |-> nodeId == nvmNodeId; endproperty
    a_id: assert property (p_id) else $error("memory id");
    property p_same; configValid && fieldBusVariant && !nodeIdFromNvm |-> nodeId == moduleAddress; endproperty
    a_same: assert property (p_same) else $error("id differs");
    property p_uv; !mainSupplyOk |=> underVoltage && !ready; endproperty
    a_uv: assert property (p_uv) else $error("no undervoltage");
    property p_rdy; configValid && mainSupplyOk |=> ready && !underVoltage; endproperty
    a_rdy: assert property (p_rdy) else $error("not ready");
endmodule
bind nasd_node_address_decode nasd_checker i_nasd_checker (.clock, .rst_n, .fieldBusVariant,
    .mainSupplyOk, .configValid, .ready, .underVoltage, .nodeIdFromNvm, .bitRateFromNvm,
    .softwareAddress, .nvmNodeId, .moduleAddress, .nodeId, .nvmBitRate, .bitRateSel);

// ==== sim/tb_node_address_switch_decode.sv ====
// bench: one decode per reset, edge codes then random codes
// assumes model and checker files are compiled first
`timescale 1ns/100ps
module tb_node_address_switch_decode;
    reg         clock = 0, rst_n = 0, fieldBusVariant = 0, mainSupplyOk = 1, seen = 0;
    reg  [3:0]  switchLeft = 0, switchRight = 0;
    reg  [15:0] seed = 0;
    reg  [31:0] lfsr = 32'h3841AD3A;
    reg  [7:0]  v, a;
    reg  [20:0] e;
    int         error_cnt = 0, check_count = 0, i, n;
    logic [20:0] expQ[$];
    wire [7:0]  softwareAddress, nvmNodeId, moduleAddress, nodeId;
    wire [2:0]  nvmBitRate, bitRateSel;
    wire        nodeIdFromNvm, bitRateFromNvm, configValid, ready, underVoltage;
    nasd_nvm_model i_nasd_nvm_model (.seed, .softwareAddress, .nvmNodeId, .nvmBitRate);
    nasd_node_address_decode i_nasd_node_address_decode (.clock, .rst_n, .switchLeft,
        .switchRight, .fieldBusVariant, .softwareAddress, .nvmNodeId, .nvmBitRate,
        .mainSupplyOk, .moduleAddress, .nodeId, .bitRateSel, .nodeIdFromNvm,
        .bitRateFromNvm, .configValid, .ready, .underVoltage);
    initial forever #2.5 clock = ~clock;
    function [31:0] nxt(input [31:0] s);
        nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic [20:0] got, input logic [20:0] e);
        check_count++;
        if (got !== e) begin
            error_cnt++;
            $display("wrong value %0t got %h exp %h", $time, got, e);
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // first latched result after each reset against the oldest note
    always @(negedge clock) begin
        if (!rst_n) seen = 0;
        else if (configValid === 1'b1 && !seen) begin
            seen = 1;
            chk({moduleAddress, nodeId, bitRateSel, nodeIdFromNvm, bitRateFromNvm}, expQ.pop_front());
        end
    end
    // codes 00 01 7F 80 81 FF on both variants, then random codes
    initial begin
        for (i = 0; i < 24; i++) begin
            lfsr = nxt(lfsr);
            v = i < 12 ? 48'h00017F8081FF >> (8 * (i % 6)) : lfsr[7:0];
            rst_n = 0;
            fieldBusVariant = i < 12 ? i / 6 : lfsr[8];
            mainSupplyOk = 1;
            {switchRight, switchLeft} = v;
            seed = lfsr[31:16];
            a = v[6:0] == 0 ? seed[7:0] | 8'h01 : {1'b0, v[6:0]};
            if (!fieldBusVariant) e = {a, 13'h0};
            else e = {a, v[6:0] == 0 ? {1'b0, seed[14:8]} : a,
                v[7] ? seed[15:13] : 3'h0, v[6:0] == 0, v[7]};
            expQ.push_back(e);
            repeat (5) @(negedge clock);
            rst_n = 1;
            for (n = 0; configValid !== 1'b1 && n < 2100; n++) @(negedge clock);
            if (n == 2100) begin error_cnt++; finish_test; end
            {switchRight, switchLeft} = ~v;
            repeat (3) @(negedge clock);
            chk({ready, underVoltage}, 21'h2);
            chk({moduleAddress, nodeId, bitRateSel, nodeIdFromNvm, bitRateFromNvm}, e);
            mainSupplyOk = 0;
            @(negedge clock);
            chk({ready, underVoltage}, 21'h1);
            mainSupplyOk = 1;
            @(negedge clock);
            chk({ready, underVoltage}, 21'h2);
            $display("test %0d code %h done", i, v);
        end
        finish_test;
    end
endmodule
